// *** adc_source_model.sv ***
// Purpose: converter model driving both sample ports
// Assumes: constant words, port A qualifier dense or one clock in four (port B three in four)
// Notes:   words are inverted while not qualified
`timescale 1ns/1ns
module adc_source_model (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                sparse,
  output nco_tuner_pkg::adc_port_t port_a,
  output nco_tuner_pkg::adc_port_t port_b
);
  logic [1:0] cnt;
  logic       qa;
  wire        qb = sparse ? !qa : qa;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 2'h0;
      qa  <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      qa  <= !sparse || cnt == 2'h3;
    end
  end
  // stale words are not left on the lines while unqualified
  assign port_a = {qa ? 14'h1000 : 14'h2FFF, 3'h5, qa};
  assign port_b = {qb ? 14'h0800 : 14'h37FF, 3'h2, qb};
endmodule : adc_source_model

// *** nco_sincos.sv ***
// Purpose: phase to cosine/sine conversion with amplitude dither
// Assumes: 16-bit phase, one full turn over the code range
// Notes:   parabolic half-wave shape, one cycle of latency
`timescale 1ns/1ns
module nco_sincos (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [15:0]        phase,
  input  wire logic               amp_dither_en,
  output logic signed [15:0]      cosine,
  output logic signed [15:0]      sine
);

  logic [15:0] amp_lfsr;
  logic [3:0]  amp_dither;
  logic [15:0] cos_phase;

  // parabola x*(1-x) per half turn; dither sits below the output lsb
  function automatic logic signed [15:0] half_wave(input logic [15:0] p,
                                                   input logic [3:0] d);
    logic [15:0] x;
    logic [31:0] prod;
    logic [16:0] mag;
    logic [15:0] sat;
    x    = {1'b0, p[14:0]};
    prod = x * (nco_tuner_pkg::HALF_SPAN - x) + {19'h00000, d, 9'h000};
    mag  = prod[29:13];
    sat  = (mag > nco_tuner_pkg::AMP_MAX) ? nco_tuner_pkg::AMP_MAX[15:0]
                                           : mag[15:0];
    return p[15] ? -$signed(sat) : $signed(sat);
  endfunction : half_wave

  // --------------------------------------------------------------
  // amplitude dither source
  // --------------------------------------------------------------
  // runs freely so enabling dither never restarts its sequence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      amp_lfsr <= nco_tuner_pkg::AMP_LFSR_SEED;
    end else begin
      amp_lfsr <= nco_tuner_pkg::lfsr_step(amp_lfsr);
    end
  end

  assign amp_dither = amp_dither_en ? amp_lfsr[3:0] : 4'h0;
  assign cos_phase  = phase + nco_tuner_pkg::QUARTER_TURN;

  // --------------------------------------------------------------
  // conversion
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cosine <= 16'sh0000;
      sine   <= 16'sh0000;
    end else begin
      cosine <= half_wave(cos_phase, amp_dither);
      sine   <= half_wave(phase, amp_dither);
    end
  end

endmodule : nco_sincos

// *** nco_tuner_input_qualify.sv ***
// Purpose: one channel's oscillator tuner and input qualifier
// Assumes: ADC ports are driven on clk, soft_sync is a clk pulse
// Notes:   sample to mixer output takes three clocks
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module nco_tuner_input_qualify (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [15:0]                    reg_rdata,
  input  wire nco_tuner_pkg::adc_port_t  port_a_samples,
  input  wire nco_tuner_pkg::adc_port_t  port_b_samples,
  input  wire logic                      soft_sync,
  output nco_tuner_pkg::mixer_out_t      mix_out,
  output logic                           hop_pulse
);

  // mixing product scaled back to 16 bits; full scale trig gives 2x
  function automatic logic signed [15:0] mix_scale(
      input logic signed [13:0] s,
      input logic signed [15:0] t);
    logic signed [29:0] p;
    p = 30'(s) * 30'(t);
    return p[29:14];
  endfunction : mix_scale

  // bypass path with the same gain as the mixer at full scale
  function automatic logic signed [15:0] pass_scale(
      input logic [13:0] s);
    return {s[13], s, 1'b0};
  endfunction : pass_scale

  // --------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------
  logic [15:0] tw_part_a;
  logic [15:0] tw_part_b;
  logic [15:0] phase_offset;
  logic [15:0] control;

  wire hit_holdoff = reg_addr == nco_tuner_pkg::HOLDOFF_ADDR;
  wire hit_tw_a    = reg_addr == nco_tuner_pkg::TW_PART_A_ADDR;
  wire hit_tw_b    = reg_addr == nco_tuner_pkg::TW_PART_B_ADDR;
  wire hit_phase   = reg_addr == nco_tuner_pkg::PHASE_OFS_ADDR;
  wire hit_control = reg_addr == nco_tuner_pkg::CONTROL_ADDR;

  wire wr_holdoff  = reg_wr && hit_holdoff;
  wire wr_tw_a     = reg_wr && hit_tw_a;
  wire wr_tw_b     = reg_wr && hit_tw_b;
  wire wr_phase    = reg_wr && hit_phase;
  wire wr_control  = reg_wr && hit_control;

  // control fields
  wire       bypass       = control[nco_tuner_pkg::CTL_BYPASS];
  wire       phase_dith   = control[nco_tuner_pkg::CTL_PHASE_DITHER];
  wire       amp_dith     = control[nco_tuner_pkg::CTL_AMP_DITHER];
  wire       clear_on_hop = control[nco_tuner_pkg::CTL_CLEAR_ON_HOP];
  wire [1:0] qmode        = control[nco_tuner_pkg::CTL_QMODE_LSB +: 2];
  wire       use_port_b   = control[nco_tuner_pkg::CTL_PORT_B_SEL];

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  // every register is private to this channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tw_part_a    <= nco_tuner_pkg::TW_PART_RST;
      tw_part_b    <= nco_tuner_pkg::TW_PART_RST;
      phase_offset <= nco_tuner_pkg::PHASE_OFS_RST;
      control      <= nco_tuner_pkg::CONTROL_RST;
    end else begin
      if (wr_tw_a) begin
        tw_part_a <= reg_wdata;
      end
      if (wr_tw_b) begin
        tw_part_b <= reg_wdata;
      end
      if (wr_phase) begin
        phase_offset <= reg_wdata;
      end
      if (wr_control) begin
        control <= reg_wdata & nco_tuner_pkg::CONTROL_MASK;
      end
    end
  end

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  logic [15:0] holdoff_count;
  logic [15:0] read_value;

  // the hold-off offset reads back the live count, not the load value
  assign read_value = hit_holdoff ? holdoff_count :
                      hit_tw_a    ? tw_part_a :
                      hit_tw_b    ? tw_part_b :
                      hit_phase   ? phase_offset :
                      hit_control ? control :
                                    16'h0000;

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? read_value : 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // hold-off counter
  // --------------------------------------------------------------
  nco_tuner_pkg::holdoff_state_t hold_state;
  nco_tuner_pkg::holdoff_state_t next_hold_state;
  logic [15:0] next_holdoff_count;
  logic        holdoff_expire;

  // a write arms the counter; a write while counting restarts it
  always_comb begin
    next_hold_state    = hold_state;
    next_holdoff_count = holdoff_count;
    holdoff_expire     = 1'b0;
    unique case (hold_state)
      nco_tuner_pkg::HOLD_IDLE: begin
      end
      nco_tuner_pkg::HOLD_COUNT: begin
        if (holdoff_count == 16'h0000) begin
          holdoff_expire  = 1'b1;
          next_hold_state = nco_tuner_pkg::HOLD_IDLE;
        end else begin
          next_holdoff_count = holdoff_count - 16'h0001;
        end
      end
      default: begin
        next_hold_state = nco_tuner_pkg::HOLD_IDLE;
      end
    endcase
    if (wr_holdoff) begin
      next_holdoff_count = reg_wdata;
      next_hold_state    = nco_tuner_pkg::HOLD_COUNT;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_state    <= nco_tuner_pkg::HOLD_IDLE;
      holdoff_count <= nco_tuner_pkg::HOLDOFF_RST;
    end else begin
      hold_state    <= next_hold_state;
      holdoff_count <= next_holdoff_count;
    end
  end

  // --------------------------------------------------------------
  // active tuning word
  // --------------------------------------------------------------
  logic [31:0] active_tuning;

  wire [31:0] shadow_tuning = {tw_part_b, tw_part_a};
  wire        tw_transfer   = soft_sync || holdoff_expire;

  // a shadow write in the transfer cycle misses this transfer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_tuning <= 32'h0000_0000;
      hop_pulse     <= 1'b0;
    end else begin
      hop_pulse <= holdoff_expire;
      if (tw_transfer) begin
        active_tuning <= shadow_tuning;
      end
    end
  end

  // --------------------------------------------------------------
  // input qualifier handling
  // --------------------------------------------------------------
  logic qual_prev;

  wire nco_tuner_pkg::adc_port_t sel_port =
      use_port_b ? port_b_samples : port_a_samples;
  wire qual      = sel_port.qualifier;
  wire qual_rise = qual && !qual_prev;
  wire qual_fall = !qual && qual_prev;

  wire mode_blank = qmode == nco_tuner_pkg::QMODE_BLANK;
  wire mode_level = qmode == nco_tuner_pkg::QMODE_LEVEL;
  wire mode_rise  = qmode == nco_tuner_pkg::QMODE_RISE;
  wire mode_fall  = qmode == nco_tuner_pkg::QMODE_FALL;

  // blank mode takes a word every clock, zeros while low
  wire take_sample = mode_blank ||
                     (mode_level && qual) ||
                     (mode_rise && qual_rise) ||
                     (mode_fall && qual_fall);
  wire zero_sample = mode_blank && !qual;

  // edge modes step once per captured word, level mode holds when low
  wire nco_advance = mode_blank ||
                     (mode_level && qual) ||
                     (mode_rise && qual_rise) ||
                     (mode_fall && qual_fall);

  // downstream filters idle only in blank mode with qualifier low
  wire filter_step = mode_blank ? qual : 1'b1;

  // --------------------------------------------------------------
  // sample capture, stage 1
  // --------------------------------------------------------------
  logic [13:0] cap_main;
  logic [13:0] cap_b;
  logic [2:0]  cap_exp;
  logic        cap_new;
  logic        cap_step;

  // port B is also held for the quadrature leg of bypass
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_main <= 14'h0000;
      cap_b    <= 14'h0000;
      cap_exp  <= 3'h0;
      cap_new  <= 1'b0;
      cap_step <= 1'b0;
      qual_prev <= 1'b0;
    end else begin
      cap_new  <= take_sample;
      cap_step <= filter_step;
      qual_prev <= qual;
      if (take_sample) begin
        cap_main <= zero_sample ? 14'h0000 : sel_port.samples;
        cap_b    <= zero_sample ? 14'h0000 : port_b_samples.samples;
        cap_exp  <= sel_port.exponent;
      end
    end
  end

  // --------------------------------------------------------------
  // phase accumulator and phase dither
  // --------------------------------------------------------------
  logic [31:0] phase_acc;
  logic [15:0] phase_lfsr;
  logic [15:0] phase_word;

  wire [15:0] phase_dither = phase_dith ? phase_lfsr : 16'h0000;
  // offset sits in the top half, dither in the discarded half
  wire [31:0] phase_sum = phase_acc
                        + {phase_offset, 16'h0000}
                        + {16'h0000, phase_dither};
  wire        hop_clear = holdoff_expire && clear_on_hop;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_acc <= 32'h0000_0000;
    end else if (hop_clear) begin
      phase_acc <= 32'h0000_0000;
    end else if (nco_advance) begin
      phase_acc <= phase_acc + active_tuning;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_lfsr <= nco_tuner_pkg::PHASE_LFSR_SEED;
    end else begin
      phase_lfsr <= nco_tuner_pkg::lfsr_step(phase_lfsr);
    end
  end

  // phase is taken in the capture cycle, before that cycle's step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_word <= 16'h0000;
    end else begin
      phase_word <= phase_sum[31:16];
    end
  end

  // --------------------------------------------------------------
  // quadrature generation, stage 2
  // --------------------------------------------------------------
  logic signed [15:0] osc_cos;
  logic signed [15:0] osc_sin;

  nco_sincos u_sincos (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .phase         (phase_word),
    .amp_dither_en (amp_dith),
    .cosine        (osc_cos),
    .sine          (osc_sin)
  );

  logic [13:0] dly_main;
  logic [13:0] dly_b;
  logic [2:0]  dly_exp;
  logic        dly_new;
  logic        dly_step;

  // samples wait one clock so they meet their own oscillator phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dly_main <= 14'h0000;
      dly_b    <= 14'h0000;
      dly_exp  <= 3'h0;
      dly_new  <= 1'b0;
      dly_step <= 1'b0;
    end else begin
      dly_main <= cap_main;
      dly_b    <= cap_b;
      dly_exp  <= cap_exp;
      dly_new  <= cap_new;
      dly_step <= cap_step;
    end
  end

  // --------------------------------------------------------------
  // mixer, stage 3
  // --------------------------------------------------------------
  wire signed [15:0] neg_sin = 16'(-osc_sin);
  wire signed [15:0] mix_i   = mix_scale(dly_main, osc_cos);
  wire signed [15:0] mix_q   = mix_scale(dly_main, neg_sin);
  wire signed [15:0] pass_i  = pass_scale(dly_main);
  wire signed [15:0] pass_q  = pass_scale(dly_b);

  // bypass I follows the selected port; clear bit six to have port A as I
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mix_out <= '0;
    end else begin
      mix_out.in_phase    <= bypass ? pass_i : mix_i;
      mix_out.quadrature  <= bypass ? pass_q : mix_q;
      mix_out.exponent    <= dly_exp;
      mix_out.sample_new  <= dly_new;
      mix_out.filter_step <= dly_step;
    end
  end

endmodule : nco_tuner_input_qualify

// *** nco_tuner_input_qualify_props.sv ***
// Purpose: port-level checks for the tuner front end
// Assumes: control register mirrored from bus writes
// Notes:   dither is enabled by the bench only by the register test's all-ones control write
`timescale 1ns/1ns
module nco_tuner_input_qualify_props (
  input wire logic                      clk,
  input wire logic                      sys_rst,
  input wire logic [7:0]                reg_addr,
  input wire logic [15:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [15:0]               reg_rdata,
  input wire nco_tuner_pkg::adc_port_t  port_a_samples,
  input wire nco_tuner_pkg::adc_port_t  port_b_samples,
  input wire logic                      soft_sync,
  input wire nco_tuner_pkg::mixer_out_t mix_out,
  input wire logic                      hop_pulse
);
  // ---------------------------------------------------------------
  // mode mirror
  // ---------------------------------------------------------------
  logic [6:0] ctl;
  wire  [1:0] qmode = ctl[5:4];
  wire        sel_q = ctl[6] ? port_b_samples.qualifier : port_a_samples.qualifier;
  wire        blank = qmode == nco_tuner_pkg::QMODE_BLANK;
  // mode is not visible at the ports, so track the writes
  always_ff @(posedge clk) begin
    if (sys_rst) ctl <= 7'h00;
    else if (reg_wr && reg_addr == nco_tuner_pkg::CONTROL_ADDR) ctl <= reg_wdata[6:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_arm_two;
    reg_wr && reg_addr == nco_tuner_pkg::HOLDOFF_ADDR && reg_wdata == 16'h0002;
  endsequence
  sequence s_rise;
    qmode == nco_tuner_pkg::QMODE_RISE && $rose(sel_q);
  endsequence
  sequence s_fall;
    qmode == nco_tuner_pkg::QMODE_FALL && $fell(sel_q);
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h84 || reg_addr > 8'h88)
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_hop_timing: assert property (s_arm_two |=> !hop_pulse [*3] ##1 hop_pulse)
    else $error("hop not three clocks after arming");
  chk_hop_single: assert property (hop_pulse |=> !hop_pulse)
    else $error("hop pulse too long");
  chk_blank_zero: assert property (blank && !ctl[0] && !sel_q |-> ##3
    mix_out.in_phase == 16'h0000 && mix_out.quadrature == 16'h0000) else $error("blank not zero");
  chk_level_capture: assert property (qmode == nco_tuner_pkg::QMODE_LEVEL
    |-> ##3 mix_out.sample_new == $past(sel_q, 3)) else $error("level capture wrong");
  chk_rise_capture: assert property (s_rise |-> ##3 mix_out.sample_new)
    else $error("no capture after rise");
  chk_fall_capture: assert property (s_fall |-> ##3 mix_out.sample_new)
    else $error("no capture after fall");
  chk_bypass_route: assert property (ctl[0] && blank && sel_q && !ctl[6] |-> ##3
    mix_out.in_phase == $past({port_a_samples.samples[13], port_a_samples.samples, 1'b0}, 3))
    else $error("bypass in-phase wrong");
endmodule : nco_tuner_input_qualify_props

bind nco_tuner_input_qualify nco_tuner_input_qualify_props u_props (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_a_samples(port_a_samples), .port_b_samples(port_b_samples),
  .soft_sync(soft_sync), .mix_out(mix_out), .hop_pulse(hop_pulse));

// *** nco_tuner_pkg.sv ***
// Purpose: shared constants and types for the tuner front end
// Assumes: 8-bit register address, 16-bit register data
// Notes:   register offsets are byte addresses on the plain port
package nco_tuner_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] HOLDOFF_ADDR = 8'h84;
  localparam logic [7:0] TW_PART_A_ADDR = 8'h85;
  localparam logic [7:0] TW_PART_B_ADDR = 8'h86;
  localparam logic [7:0] PHASE_OFS_ADDR = 8'h87;
  localparam logic [7:0] CONTROL_ADDR = 8'h88;

  localparam logic [15:0] HOLDOFF_RST = 16'h0000;
  localparam logic [15:0] TW_PART_RST = 16'h0000;
  localparam logic [15:0] PHASE_OFS_RST = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] CONTROL_MASK = 16'h007F;

  // -------------------------------------------------------------
  // control field positions
  // -------------------------------------------------------------
  localparam int unsigned CTL_BYPASS = 0;
  localparam int unsigned CTL_PHASE_DITHER = 1;
  localparam int unsigned CTL_AMP_DITHER = 2;
  localparam int unsigned CTL_CLEAR_ON_HOP = 3;
  localparam int unsigned CTL_QMODE_LSB = 4;
  localparam int unsigned CTL_PORT_B_SEL = 6;

  // qualifier handling modes
  localparam logic [1:0] QMODE_BLANK = 2'h0;
  localparam logic [1:0] QMODE_LEVEL = 2'h1;
  localparam logic [1:0] QMODE_RISE = 2'h2;
  localparam logic [1:0] QMODE_FALL = 2'h3;

  // -------------------------------------------------------------
  // pseudo-random generators and oscillator constants
  // -------------------------------------------------------------
  localparam logic [15:0] PHASE_LFSR_SEED = 16'hACE1;
  localparam logic [15:0] AMP_LFSR_SEED = 16'h5A3C;
  localparam logic [15:0] QUARTER_TURN = 16'h4000;
  localparam logic [15:0] HALF_SPAN = 16'h8000;
  localparam logic [16:0] AMP_MAX = 17'h07FFF;

  typedef enum logic [1:0] {
    HOLD_IDLE  = 2'b01,
    HOLD_COUNT = 2'b10
  } holdoff_state_t;

  typedef struct packed {
    logic [13:0] samples;
    logic [2:0]  exponent;
    logic        qualifier;
  } adc_port_t;

  typedef struct packed {
    logic signed [15:0] in_phase;
    logic signed [15:0] quadrature;
    logic [2:0]         exponent;
    logic               sample_new;
    logic               filter_step;
  } mixer_out_t;

  // maximal-length 16-bit Fibonacci step, taps 16 14 13 11
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

endpackage : nco_tuner_pkg

// *** tb_top.sv ***
// Purpose: self-checking bench for the tuner front end
// Assumes: constant converter words, dither off
// Notes:   phase checks look for change, not exact trig values
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic                     clk       = 1'b0;
  logic                     sys_rst   = 1'b1;
  logic                     sparse    = 1'b0;
  logic                     soft_sync = 1'b0;
  logic                     reg_wr    = 1'b0;
  logic                     reg_rd    = 1'b0;
  logic [7:0]               reg_addr  = 8'h00;
  logic [15:0]              reg_wdata = 16'h0000;
  logic [15:0]              reg_rdata;
  logic                     hop_pulse;
  nco_tuner_pkg::adc_port_t pa;
  nco_tuner_pkg::adc_port_t pb;
  nco_tuner_pkg::mixer_out_t mix_out;
  int                       mismatches = 0;
  int                       n_checks   = 0;
  int                       cycles     = 0;
  adc_source_model u_adc_source_model (.clk(clk), .sys_rst(sys_rst), .sparse(sparse),
    .port_a(pa), .port_b(pb));
  nco_tuner_input_qualify u_nco_tuner_input_qualify (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_a_samples(pa), .port_b_samples(pb),
    .soft_sync(soft_sync), .mix_out(mix_out), .hop_pulse(hop_pulse));
  always #5 clk = ~clk;
  // ---------------------------------------------------------------
  // bus and observation helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // quadrature only moves when the phase moves, given a constant word
  task automatic watch(output bit ch, output logic [15:0] first);
    repeat (6) @(posedge clk);
    #1 first = mix_out.quadrature;
    ch = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1 if (mix_out.quadrature !== first) ch = 1'b1;
    end
  endtask : watch
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [15:0] d;
    for (int i = 0; i < 5; i++) begin
      rd(8'h84 + 8'(i), d);
      `CHK(d, 16'h0000)
    end
    for (int i = 1; i < 5; i++) begin
      wr(8'h84 + 8'(i), 16'hFFFF);
      rd(8'h84 + 8'(i), d);
      `CHK(d, i == 4 ? nco_tuner_pkg::CONTROL_MASK : 16'hFFFF)
      wr(8'h84 + 8'(i), 16'h0000);
    end
    wr(8'h89, 16'hFFFF);
    rd(8'h89, d);
    `CHK(d, 16'h0000)
    wr(nco_tuner_pkg::HOLDOFF_ADDR, 16'h0002);
    rd(nco_tuner_pkg::HOLDOFF_ADDR, d);
    `CHK(d, 16'h0001)
    repeat (4) @(posedge clk);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_tune();
    bit          ch;
    int          k;
    logic [15:0] q0;
    logic [15:0] q;
    watch(ch, q0);
    `CHK(ch, 1'b0)
    wr(nco_tuner_pkg::TW_PART_A_ADDR, 16'h5678);
    wr(nco_tuner_pkg::TW_PART_B_ADDR, 16'h1234);
    watch(ch, q);
    `CHK(ch, 1'b0)
    @(posedge clk);
    soft_sync <= 1'b1;
    @(posedge clk);
    soft_sync <= 1'b0;
    watch(ch, q);
    `CHK(ch, 1'b1)
    wr(nco_tuner_pkg::TW_PART_A_ADDR, 16'h0000);
    wr(nco_tuner_pkg::TW_PART_B_ADDR, 16'h0000);
    wr(nco_tuner_pkg::CONTROL_ADDR, 16'h0008);
    wr(nco_tuner_pkg::HOLDOFF_ADDR, 16'h0005);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (hop_pulse !== 1'b1 && k < 40);
    `CHK(k, 6)
    watch(ch, q);
    `CHK({ch, q}, {1'b0, q0})
    wr(nco_tuner_pkg::PHASE_OFS_ADDR, 16'h4000);
    watch(ch, q);
    `CHK(q !== q0, 1'b1)
    wr(nco_tuner_pkg::PHASE_OFS_ADDR, 16'h0000);
    $display("t_tune done");
  endtask : t_tune
  task automatic t_bypass();
    wr(nco_tuner_pkg::CONTROL_ADDR, 16'h0001);
    repeat (5) @(posedge clk);
    #1 `CHK({mix_out.in_phase, mix_out.quadrature}, 32'h20001000)
    `CHK(mix_out.exponent, 3'h5)
    wr(nco_tuner_pkg::CONTROL_ADDR, 16'h0041);
    repeat (5) @(posedge clk);
    #1 `CHK(mix_out.in_phase, 16'h1000)
    `CHK(mix_out.exponent, 3'h2)
    $display("t_bypass done");
  endtask : t_bypass
  task automatic t_modes();
    logic [15:0] ctab [5] = '{16'h0010, 16'h0050, 16'h0020, 16'h0030, 16'h0000};
    int          stab [5] = '{10, 30, 10, 10, 40};
    int          ftab [5] = '{40, 40, 40, 40, 10};
    int          sn;
    int          fs;
    int          qc;
    logic [15:0] qp;
    // a moving oscillator makes held words show each phase step
    wr(nco_tuner_pkg::TW_PART_B_ADDR, 16'h1234);
    @(posedge clk);
    sparse    <= 1'b1;
    soft_sync <= 1'b1;
    @(posedge clk);
    soft_sync <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(nco_tuner_pkg::CONTROL_ADDR, ctab[i]);
      repeat (6) @(posedge clk);
      #1 qp = mix_out.quadrature;
      sn = 0;
      fs = 0;
      qc = 0;
      repeat (40) begin
        @(posedge clk);
        #1 sn += (mix_out.sample_new === 1'b1);
        fs += (mix_out.filter_step === 1'b1);
        qc += (mix_out.quadrature !== qp);
        qp = mix_out.quadrature;
      end
      `CHK(sn, stab[i])
      `CHK(fs, ftab[i])
      if (i < 4) `CHK(qc <= sn + 1, 1'b1)
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_tune();
    t_bypass();
    t_modes();
    give_verdict();
  end
endmodule : tb_top
